// ### src/mbs_regs.vh
`ifndef MBS_REGS_VH
`define MBS_REGS_VH

// Clock and tick timing
`define MBS_CLK_NS        32'h0000_0014
`define MBS_TICK_NS       32'h000F_4240
`define MBS_MS_PER_S      16'h03E8

// Second-scale intervals, figures in seconds or milliseconds
`define MBS_STAR1_S       16'h0014
`define MBS_STAR2_S       16'h000F
`define MBS_STAR3_S       16'h000A
`define MBS_STAR4_S       16'h0005
`define MBS_MAXBRAKE_S    16'h000A
`define MBS_HOLDOFF_S     16'h0002
`define MBS_MINCUR_S      16'h0002
`define MBS_SAFE_MS       16'h00C8
`define MBS_NOCUR_MS      16'h01F4
`define MBS_FLASH_ON_MS   16'h012C
`define MBS_FLASH_OFF_MS  16'h012C
`define MBS_FLASH_GAP_MS  16'h05DC

// Selector positions
`define MBS_SEL_DOL       3'h0
`define MBS_SEL_EXT       3'h5
`define MBS_SEL_RST       3'h1

// Fault flash counts
`define MBS_FLT_NONE      3'h0
`define MBS_FLT_FREQ      3'h1
`define MBS_FLT_NOCUR     3'h2
`define MBS_FLT_HOT       3'h3
`define MBS_FLT_SYNC      3'h4
`define MBS_FLT_TEMP      3'h5
`define MBS_FLT_LIVE      3'h6

// Register byte offsets
`define MBS_ADR_CTRL      8'h00
`define MBS_ADR_STAT      8'h04

// Pin vector positions
`define MBS_PIN_N         4'hA
`define MBS_PIN_RST       10'h001
`define MBS_P_CONTACT     0
`define MBS_P_SSENSE      1
`define MBS_P_T3CONN      2
`define MBS_P_CURR        3
`define MBS_P_CURSTILL    4
`define MBS_P_MOTLIVE     5
`define MBS_P_FREQ        6
`define MBS_P_HOT         7
`define MBS_P_SYNC        8
`define MBS_P_TEMP        9

`endif

// ### src/mbs_sequencer.v
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "mbs_regs.vh"

module mbs_sequencer #(
    parameter [31:0] TICK_CYCLES = `MBS_TICK_NS / `MBS_CLK_NS
) (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        nrst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Field inputs, asynchronous
    input  wire        contactor_feedback_input_i,
    input  wire        standstill_sense_input_i,
    input  wire        sense_connected_i,
    input  wire        brake_current_i,
    input  wire        current_standstill_i,
    input  wire        motor_live_i,
    input  wire        freq_fault_i,
    input  wire        overheat_i,
    input  wire        sync_missing_i,
    input  wire        temp_fault_i,
    // Relays and indicators
    output reg         interlock_output_o,
    output reg         star_relay_o,
    output reg         delta_ready_relay_o,
    output reg         standstill_relay_o,
    output reg         brake_contactor_o,
    output reg         green_led_o,
    output reg         error_led_o
);

    // One-hot states
    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_STAR  = 7'h02;
    localparam [6:0] ST_RUN   = 7'h04;
    localparam [6:0] ST_SAFE  = 7'h08;
    localparam [6:0] ST_HOLD  = 7'h10;
    localparam [6:0] ST_BRAKE = 7'h20;
    localparam [6:0] ST_FAULT = 7'h40;

    localparam [15:0] TICK_LAST   = TICK_CYCLES[15:0] - 16'h0001;
    localparam [15:0] MAXBRAKE_MS = `MBS_MAXBRAKE_S * `MBS_MS_PER_S;
    localparam [15:0] HOLDOFF_MS  = `MBS_HOLDOFF_S * `MBS_MS_PER_S;
    localparam [15:0] MINCUR_MS   = `MBS_MINCUR_S * `MBS_MS_PER_S;

    // Star delay per selector position
    function [15:0] star_ms;
        input [2:0] pos;
        begin
            case (pos)
                3'h1:    star_ms = `MBS_STAR1_S * `MBS_MS_PER_S;
                3'h2:    star_ms = `MBS_STAR2_S * `MBS_MS_PER_S;
                3'h3:    star_ms = `MBS_STAR3_S * `MBS_MS_PER_S;
                3'h4:    star_ms = `MBS_STAR4_S * `MBS_MS_PER_S;
                default: star_ms = 16'h0000;
            endcase
        end
    endfunction

    reg  [9:0]  pin_s1;
    reg  [9:0]  pin_s2;
    reg  [9:0]  pin_s3;
    reg  [9:0]  pin;
    reg  [15:0] pre;
    reg         tick;
    reg  [6:0]  state;
    reg  [6:0]  next_state;
    reg  [15:0] tmr;
    reg  [2:0]  selector;
    reg  [2:0]  flt_code;
    reg  [2:0]  next_flt;
    reg         stand_det;
    reg         next_stand;
    reg         stopped_by_max;
    reg  [15:0] flash_tmr;
    reg  [2:0]  flash_n;
    wire        contact_closed;
    wire        internal_sd;
    wire        still_now;
    wire        wb_req;

    assign contact_closed = pin[`MBS_P_CONTACT];
    assign internal_sd    = (selector != `MBS_SEL_DOL) &&
                            (selector < `MBS_SEL_EXT);
    assign wb_req         = wb_cyc_i & wb_stb_i;
    // Standstill from sense pin, or from current after minimum flow
    assign still_now = pin[`MBS_P_T3CONN] ? pin[`MBS_P_SSENSE] :
                       (pin[`MBS_P_CURSTILL] && tmr > MINCUR_MS);

    // Three-stage input sync, accept once stages two and three agree
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // Stages start at idle pin levels so no false start follows reset
            pin_s1 <= `MBS_PIN_RST;
            pin_s2 <= `MBS_PIN_RST;
            pin_s3 <= `MBS_PIN_RST;
            pin    <= `MBS_PIN_RST;
        end else begin
            pin_s1 <= {temp_fault_i, sync_missing_i, overheat_i,
                       freq_fault_i, motor_live_i, current_standstill_i,
                       brake_current_i, sense_connected_i,
                       standstill_sense_input_i, contactor_feedback_input_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            // Hold the accepted value while stages two and three differ
            pin    <= (pin & (pin_s2 ^ pin_s3)) |
                      (pin_s3 & ~(pin_s2 ^ pin_s3));
        end
    end

    // Millisecond tick prescaler
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre  <= 16'h0000;
            tick <= 1'b0;
        end else if (pre == TICK_LAST) begin
            pre  <= 16'h0000;
            tick <= 1'b1;
        end else begin
            pre  <= pre + 16'h0001;
            tick <= 1'b0;
        end
    end

    // Sequencer next-state decision
    always @* begin
        next_state = state;
        next_flt   = flt_code;
        next_stand = stand_det;
        case (state)
            // Contact opening means the motor contactor has pulled in
            ST_IDLE: begin
                if (!contact_closed) begin
                    next_stand = 1'b0;
                    if (internal_sd)
                        next_state = ST_STAR;
                    else
                        next_state = ST_RUN;
                end
            end
            ST_STAR: begin
                if (contact_closed)
                    next_state = ST_SAFE;
                else if (tmr >= star_ms(selector))
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (contact_closed)
                    next_state = ST_SAFE;
            end
            ST_SAFE: begin
                if (tmr >= `MBS_SAFE_MS)
                    next_state = ST_HOLD;
            end
            // Back-EMF still present: wait, then give up with a fault
            ST_HOLD: begin
                if (!pin[`MBS_P_MOTLIVE])
                    next_state = ST_BRAKE;
                else if (tmr >= HOLDOFF_MS) begin
                    next_state = ST_FAULT;
                    next_flt   = `MBS_FLT_LIVE;
                end
            end
            // Standstill first, then maximum time, then missing current
            ST_BRAKE: begin
                if (still_now) begin
                    next_state = ST_IDLE;
                    next_stand = 1'b1;
                end else if (tmr >= MAXBRAKE_MS)
                    next_state = ST_IDLE;
                else if (!pin[`MBS_P_CURR] && tmr >= `MBS_NOCUR_MS) begin
                    next_state = ST_FAULT;
                    next_flt   = `MBS_FLT_NOCUR;
                end
            end
            ST_FAULT: begin
                next_state = ST_FAULT;
            end
            default: begin
                next_state = ST_FAULT;
            end
        endcase
        // Device failures override any sequence step
        if (state != ST_FAULT) begin
            if (pin[`MBS_P_FREQ]) begin
                next_state = ST_FAULT;
                next_flt   = `MBS_FLT_FREQ;
            end else if (pin[`MBS_P_HOT]) begin
                next_state = ST_FAULT;
                next_flt   = `MBS_FLT_HOT;
            end else if (pin[`MBS_P_SYNC]) begin
                next_state = ST_FAULT;
                next_flt   = `MBS_FLT_SYNC;
            end else if (pin[`MBS_P_TEMP]) begin
                next_state = ST_FAULT;
                next_flt   = `MBS_FLT_TEMP;
            end
        end
        if (next_state == ST_FAULT)
            next_stand = 1'b0;
    end

    // State, interval timer and fault latch
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state          <= ST_IDLE;
            tmr            <= 16'h0000;
            flt_code       <= `MBS_FLT_NONE;
            stand_det      <= 1'b0;
            stopped_by_max <= 1'b0;
        end else begin
            state     <= next_state;
            flt_code  <= next_flt;
            stand_det <= next_stand;
            // Timer restarts on every state change
            if (next_state != state)
                tmr <= 16'h0000;
            else if (tick && tmr != 16'hFFFF)
                tmr <= tmr + 16'h0001;
            if (state == ST_BRAKE && next_state == ST_IDLE)
                stopped_by_max <= ~next_stand;
        end
    end

    // Relay and indicator outputs, all registered
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            interlock_output_o  <= 1'b0;
            star_relay_o        <= 1'b0;
            delta_ready_relay_o <= 1'b0;
            standstill_relay_o  <= 1'b0;
            brake_contactor_o   <= 1'b0;
            green_led_o         <= 1'b0;
        end else begin
            interlock_output_o <= (state == ST_IDLE) ||
                                  (state == ST_STAR) ||
                                  (state == ST_RUN);
            star_relay_o <= (state == ST_STAR) || (state == ST_SAFE) ||
                            (state == ST_HOLD) ||
                            (state == ST_BRAKE);
            // Ready level for external timing, delta only in run
            if (selector == `MBS_SEL_EXT)
                delta_ready_relay_o <= (state == ST_IDLE) ||
                                       (state == ST_RUN);
            else
                delta_ready_relay_o <= internal_sd &&
                                       (state == ST_RUN);
            standstill_relay_o <= stand_det;
            brake_contactor_o  <= (state == ST_BRAKE);
            green_led_o        <= (state != ST_FAULT);
        end
    end

    // Error LED flash groups with a longer pause between groups
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            error_led_o <= 1'b0;
            flash_tmr   <= 16'h0000;
            flash_n     <= 3'h0;
        end else if (state != ST_FAULT) begin
            error_led_o <= 1'b0;
            flash_tmr   <= 16'h0000;
            flash_n     <= 3'h0;
        end else if (tick) begin
            if (flash_tmr != 16'h0000)
                flash_tmr <= flash_tmr - 16'h0001;
            else if (error_led_o) begin
                error_led_o <= 1'b0;
                // Count of on phases equals the latched fault code
                if (flash_n + 3'h1 >= flt_code) begin
                    flash_n   <= 3'h0;
                    flash_tmr <= `MBS_FLASH_GAP_MS;
                end else begin
                    flash_n   <= flash_n + 3'h1;
                    flash_tmr <= `MBS_FLASH_OFF_MS;
                end
            end else begin
                error_led_o <= 1'b1;
                flash_tmr   <= `MBS_FLASH_ON_MS;
            end
        end
    end

    // Wishbone slave, one wait state, unmapped reads as zero
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            selector <= `MBS_SEL_RST;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            // Write lands at the edge where ack is seen high
            if (wb_req && wb_ack_o && wb_we_i &&
                wb_adr_i == `MBS_ADR_CTRL && wb_sel_i[0])
                selector <= wb_dat_i[2:0];
            if (wb_req && !wb_ack_o) begin
                case (wb_adr_i)
                    `MBS_ADR_CTRL: wb_dat_o <= {29'h0000_0000, selector};
                    `MBS_ADR_STAT: wb_dat_o <= {8'h00, 5'h00, flt_code,
                                     1'b0, state,
                                     1'b0, stopped_by_max, stand_det,
                                     brake_contactor_o, standstill_relay_o,
                                     delta_ready_relay_o, star_relay_o,
                                     interlock_output_o};
                    default:       wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // mbs_sequencer
`default_nettype wire

// ### bench/mbs_seq_props.sv
`timescale 1ns/100ps
`default_nettype none
module mbs_seq_props #(
    parameter [31:0] TICK_CYCLES = 32'h0000_C350
) (
    // Clock, reset and bus
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Field inputs
    input wire logic sense_connected_i,
    input wire logic standstill_sense_input_i,
    // Relays and indicators
    input wire logic interlock_output_o,
    input wire logic star_relay_o,
    input wire logic delta_ready_relay_o,
    input wire logic standstill_relay_o,
    input wire logic brake_contactor_o,
    input wire logic green_led_o
);
    logic [31:0] brk_run;
    logic [31:0] safe_run;
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    // Length of a braking pulse and of the wait ahead of it
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            brk_run  <= 32'h0000_0000;
            safe_run <= 32'h0000_0000;
        end else begin
            brk_run <= brake_contactor_o ? brk_run + 1 : 32'h0000_0000;
            if (interlock_output_o)
                safe_run <= 32'h0000_0000;
            else if (green_led_o && !brake_contactor_o)
                safe_run <= safe_run + 1;
        end
    end
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("bus request not acknowledged");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_fault_open: assert property (!green_led_o |-> !(interlock_output_o
        || star_relay_o || delta_ready_relay_o || standstill_relay_o
        || brake_contactor_o)) else $error("relay closed while faulted");
    chk_brake_ilk: assert property (brake_contactor_o
        |-> !interlock_output_o) else $error("interlock closed in braking");
    chk_ilk_green: assert property (interlock_output_o |-> green_led_o)
        else $error("interlock closed without operation lamp");
    chk_brake_star: assert property (brake_contactor_o |-> star_relay_o)
        else $error("star relay open during braking");
    chk_star_delta: assert property (!(star_relay_o && delta_ready_relay_o))
        else $error("star and delta closed together");
    chk_start_clear: assert property (star_relay_o && interlock_output_o
        |-> !standstill_relay_o) else $error("standstill kept on start");
    chk_sense_end: assert property ($rose(standstill_sense_input_i)
        && sense_connected_i && brake_contactor_o
        |-> ##[1:8] !brake_contactor_o)
        else $error("braking goes on after standstill");
    chk_brake_max: assert property (brk_run <= 10002 * TICK_CYCLES)
        else $error("braking longer than maximum");
    chk_safe_wait: assert property ($rose(brake_contactor_o)
        |-> safe_run >= 199 * TICK_CYCLES) else $error("safety wait short");
endmodule // mbs_seq_props
bind mbs_sequencer mbs_seq_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .sense_connected_i(sense_connected_i),
    .standstill_sense_input_i(standstill_sense_input_i),
    .interlock_output_o(interlock_output_o), .star_relay_o(star_relay_o),
    .delta_ready_relay_o(delta_ready_relay_o),
    .standstill_relay_o(standstill_relay_o),
    .brake_contactor_o(brake_contactor_o), .green_led_o(green_led_o));
`default_nettype wire

// ### bench/mbs_plant.sv
`timescale 1ns/100ps
`default_nettype none
module mbs_plant #(
    parameter int STOP_CYC = 400
) (
    // Relay side
    input  wire logic mclk_i,
    input  wire logic brake_i,
    input  wire logic contact_i,
    // Scenario controls
    input  wire logic stop_en_i,
    input  wire logic sense_i,
    // Measurements back to the relay
    output var  logic cur_o,
    output wire logic cur_still_o,
    output wire logic sense_still_o,
    output wire logic live_o
);
    int run = 0;
    int dec = 0;
    // Current follows the braking contactor; back-EMF decays after stop
    always @(posedge mclk_i) begin
        cur_o <= brake_i;
        run   <= brake_i ? run + 1 : 0;
        dec   <= contact_i ? (dec < 200 ? dec + 1 : dec) : 0;
    end
    // Motor at rest only after enough braking, when the scenario allows
    assign live_o        = dec < 200;
    assign cur_still_o   = stop_en_i && !sense_i && run >= STOP_CYC;
    assign sense_still_o = stop_en_i && sense_i && run >= STOP_CYC;
endmodule // mbs_plant
`default_nettype wire

// ### bench/motor_brake_star_delta_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "mbs_regs.vh"
module motor_brake_star_delta_sequencer_test;
    localparam int TK = 2;
    logic        mclk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, cont = 1'b1;
    logic        sc = 1'b1, stop_en = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf, flt = 4'h0;
    logic [31:0] wd = 32'h0000_0000, q;
    wire logic [31:0] rd;
    wire logic   ack, ss, cst, cur, live, ilk, star, dly, still, brk, grn, led;
    int          err_count = 0, n_tests = 0, cycles = 0, n;
    int          code [4] = '{1, 3, 4, 5};
    mbs_sequencer #(.TICK_CYCLES(TK)) u_dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(rd), .wb_ack_o(ack), .contactor_feedback_input_i(cont),
        .standstill_sense_input_i(ss), .sense_connected_i(sc),
        .brake_current_i(cur), .current_standstill_i(cst),
        .motor_live_i(live), .freq_fault_i(flt[0]), .overheat_i(flt[1]),
        .sync_missing_i(flt[2]), .temp_fault_i(flt[3]),
        .interlock_output_o(ilk), .star_relay_o(star),
        .delta_ready_relay_o(dly), .standstill_relay_o(still),
        .brake_contactor_o(brk), .green_led_o(grn), .error_led_o(led));
    mbs_plant #(.STOP_CYC(100 * TK)) u_plant (.mclk_i(mclk_i),
        .brake_i(brk), .contact_i(cont), .stop_en_i(stop_en), .sense_i(sc),
        .cur_o(cur), .cur_still_o(cst), .sense_still_o(ss), .live_o(live));
    // Clock and hang guard
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 80000) begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
    endtask
    task automatic do_reset();
        nrst_i <= 1'b0;
        tick(12);
        nrst_i <= 1'b1;
        tick(8);
    endtask
    // One classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int t;
        t = 0;
        @(posedge mclk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        wd  <= d;
        do begin
            @(posedge mclk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        r = rd;
        chk(ack, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_brk(input logic v);
        int t;
        t = 0;
        while (brk !== v && t < 12000) begin
            @(posedge mclk_i);
            t++;
        end
        chk(brk, v);
    endtask
    // First flash, then rising edges within the window
    task automatic flashes(input int ms, output int c);
        logic p;
        int   t;
        t = 0;
        while (led !== 1'b1 && t < 3000 * TK) begin
            @(posedge mclk_i);
            t++;
        end
        p = 1'b1;
        c = (led === 1'b1) ? 1 : 0;
        repeat (ms * TK) begin
            @(posedge mclk_i);
            if (led === 1'b1 && p === 1'b0)
                c++;
            p = led;
        end
    endtask
    initial begin
        do_reset();
        chk({grn, ilk, star, dly, still, brk}, 6'b110000);
        wb(1'b0, `MBS_ADR_CTRL, 32'h0000_0000, q);
        chk(q[2:0], 3'h1);
        wb(1'b0, 8'h20, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        wb(1'b1, `MBS_ADR_CTRL, 32'h0000_0004, q);
        wb(1'b0, `MBS_ADR_CTRL, 32'h0000_0000, q);
        chk(q[2:0], 3'h4);
        cont <= 1'b0;
        tick(12);
        chk({ilk, star, dly}, 3'b110);
        tick(4980 * TK);
        chk(dly, 1'b0);
        tick(30 * TK);
        chk({ilk, star, dly}, 3'b101);
        cont <= 1'b1;
        tick(12);
        chk({ilk, star, dly, brk}, 4'b0100);
        tick(190 * TK);
        chk(brk, 1'b0);
        wait_brk(1'b1);
        wait_brk(1'b0);
        tick(3);
        chk({ilk, star, still}, 3'b101);
        wb(1'b1, `MBS_ADR_CTRL, 32'h0000_0005, q);
        tick(4);
        chk(dly, 1'b1);
        cont <= 1'b0;
        tick(12);
        chk({star, still, dly, ilk}, 4'b0011);
        sc <= 1'b0;
        stop_en <= 1'b0;
        cont <= 1'b1;
        wait_brk(1'b1);
        tick(9980 * TK);
        chk(brk, 1'b1);
        tick(40 * TK);
        chk(brk, 1'b0);
        wb(1'b0, `MBS_ADR_STAT, 32'h0000_0000, q);
        chk(q[6:5], 2'b10);
        cont <= 1'b0;
        tick(12);
        stop_en <= 1'b1;
        cont <= 1'b1;
        wait_brk(1'b1);
        tick(1990 * TK);
        chk(brk, 1'b1);
        tick(30 * TK);
        chk(brk, 1'b0);
        tick(3);
        chk(still, 1'b1);
        for (int i = 0; i < 4; i++) begin
            flt <= 4'h0;
            do_reset();
            flt <= 4'h1 << i;
            tick(10);
            chk({grn, ilk, star, dly, still, brk}, 6'b000000);
            flashes((code[i] - 1) * 600 + 900, n);
            chk(n, code[i]);
        end
        conclude();
    end
endmodule // motor_brake_star_delta_sequencer_test
`default_nettype wire
